// File: src/selftest_regs.vh
// Register offsets, field positions, reset values and timing constants for the link self test
`ifndef SELFTEST_REGS_VH
`define SELFTEST_REGS_VH

`define SELFTEST_CONTROL_OFFSET 8'h24
`define SELFTEST_ERROR_COUNT_OFFSET 8'h25
`define SELFTEST_CONTROL_RESET 8'h00

`define CTRL_RUN_BIT 0
`define CTRL_CLK_HI 2
`define CTRL_CLK_LO 1
`define CTRL_REG_SOURCE_BIT 3
`define CTRL_RESULT_BIT 4
`define CTRL_ACTIVE_BIT 5
`define CTRL_WRITE_MASK 8'h0f

`define CLK_SEL_PIXEL 2'b00
`define CLK_SEL_OSC_FAST 2'b01
`define CLK_SEL_OSC_SLOW 2'b10
`define CLK_SEL_RESERVED 2'b11

`define I2C_DEVICE_ADDR 7'h30
`define CLK_PERIOD_NS 100
`define I2C_MAX_RATE_KBPS 400
`define I2C_BIT_NS (1000000 / `I2C_MAX_RATE_KBPS)
`define I2C_BIT_CYCLES (`I2C_BIT_NS / `CLK_PERIOD_NS)
`define ERROR_PULSE_CYCLES 1

`endif

// File: src/sat_counter.v
// Saturating up counter with synchronous clear
`timescale 1ns/10ps
module sat_counter #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire reset_i,
    input wire clear_i,
    input wire inc_i,
    output wire [WIDTH-1:0] count_o
);
    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;

    always @* begin
        count_d = count_q;
        if (clear_i) begin
            count_d = {WIDTH{1'b0}};
        end else if (inc_i && (count_q != {WIDTH{1'b1}})) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;
endmodule // sat_counter

// File: src/serial_link_selftest_control.v
// Link self-test control with its I2C-compatible configuration port
//
// Notes on behaviour
// - Pins configure after reset; register 0x24 alternative
// - Pin code selects pixel clock or oscillator
// - Register bits [2:1] select clock; 11 reserved
// - Pass pulses low per errored frame
// - Consecutive errored frames give separate pulses
// - Run end shows result one cycle only
// - Status kept until new session or reset
// - Errored frame count readable at 0x25
// - Entering test enables remote pattern generator
// - Lock in test drives pass high, checks
// - Enable low stops checking, result not held
// - Enable low returns link to video
// - I2C slave writes configuration registers
// - Lines driven low or released only
// - I2C port handles up to 400 kbps
// - Remote oscillator field loaded over back channel
`timescale 1ns/10ps
`include "selftest_regs.vh"
module serial_link_selftest_control #(
    parameter COUNT_WIDTH = 8,
    parameter [6:0] DEVICE_ADDR = `I2C_DEVICE_ADDR
) (
    input wire clk_i,
    input wire reset_i,
    input wire selftest_enable_pin_i,
    input wire clock_source_select_low_i,
    input wire clock_source_select_high_i,
    input wire lock_i,
    input wire remote_in_test_i,
    input wire frame_done_i,
    input wire frame_error_i,
    input wire scl_i,
    input wire sda_i,
    output wire scl_o,
    output wire scl_oe_o,
    output wire sda_o,
    output wire sda_oe_o,
    output wire pass_o,
    output wire checking_o,
    output wire link_normal_o,
    output wire pattern_enable_o,
    output wire [1:0] remote_osc_select_o,
    output wire [1:0] clock_select_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT_LOCK = 2'd1;
    localparam ST_CHECK = 2'd2;
    localparam ST_RESULT = 2'd3;
    localparam I2_IDLE = 3'd0;
    localparam I2_ADDR = 3'd1;
    localparam I2_ACK_A = 3'd2;
    localparam I2_REG = 3'd3;
    localparam I2_ACK_R = 3'd4;
    localparam I2_WR = 3'd5;
    localparam I2_RD = 3'd6;
    localparam I2_RD_ACK = 3'd7;
    reg scl_q;
    reg sda_q;
    reg [2:0] i2c_state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg rw_q;
    reg master_ack_q;
    reg sda_oe_q;
    reg scl_oe_q;
    reg wr_q;
    reg [7:0] waddr_q;
    reg [7:0] wdata_q;
    reg [7:0] control_q;
    reg [1:0] st_state_q;
    reg pass_q;
    reg checking_q;
    reg link_normal_q;
    reg pattern_enable_q;
    reg [1:0] remote_osc_q;
    reg [1:0] clock_select_q;
    reg result_q;
    reg err_seen_q;
    reg [7:0] rdata;
    reg [1:0] clk_sel;
    reg test_en;
    wire [COUNT_WIDTH-1:0] err_count;
    wire start_cond;
    wire stop_cond;
    wire scl_rise;
    wire scl_fall;
    wire session_start;
    wire frame_bad;
    // Line events; inputs sampled every 100 ns, ample for a 2.5 us bit
    assign start_cond = scl_i && scl_q && sda_q && !sda_i;
    assign stop_cond = scl_i && scl_q && !sda_q && sda_i;
    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    // Pins rule until software claims configuration
    always @* begin
        if (control_q[`CTRL_REG_SOURCE_BIT]) begin
            test_en = control_q[`CTRL_RUN_BIT];
            clk_sel = control_q[`CTRL_CLK_HI:`CTRL_CLK_LO];
        end else begin
            test_en = selftest_enable_pin_i;
            clk_sel = {clock_source_select_high_i, clock_source_select_low_i};
        end
        // Reserved code falls back to the pixel clock rather than an undefined rate
        if (clk_sel == `CLK_SEL_RESERVED) begin
            clk_sel = `CLK_SEL_PIXEL;
        end
    end
    // Register read mux; unmapped offsets read as zero
    always @* begin
        rdata = 8'h00;
        case (ptr_q)
            `SELFTEST_CONTROL_OFFSET: begin
                rdata = control_q & `CTRL_WRITE_MASK;
                rdata[`CTRL_RESULT_BIT] = result_q;
                rdata[`CTRL_ACTIVE_BIT] = (st_state_q != ST_IDLE);
            end
            `SELFTEST_ERROR_COUNT_OFFSET: begin
                rdata = err_count[7:0];
            end
            default: begin
                rdata = 8'h00;
            end
        endcase
    end
    // I2C slave: lines only ever pulled low or released
    always @(posedge clk_i) begin
        if (reset_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            i2c_state_q <= I2_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            master_ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            wr_q <= 1'b0;
            // Register access answers at once, so the clock is never stretched
            scl_oe_q <= 1'b0;
            if (start_cond) begin
                i2c_state_q <= I2_ADDR;
                bit_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop_cond) begin
                i2c_state_q <= I2_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                case (i2c_state_q)
                    I2_ADDR, I2_REG, I2_WR: begin
                        shift_q <= {shift_q[6:0], sda_i};
                        bit_q <= bit_q + 4'h1;
                    end
                    I2_RD_ACK: begin
                        master_ack_q <= !sda_i;
                    end
                    default: begin
                        bit_q <= bit_q;
                    end
                endcase
            end else if (scl_fall) begin
                case (i2c_state_q)
                    I2_ADDR: begin
                        if (bit_q == 4'h8 && shift_q[7:1] == DEVICE_ADDR) begin
                            rw_q <= shift_q[0];
                            sda_oe_q <= 1'b1;
                            i2c_state_q <= I2_ACK_A;
                        end else if (bit_q == 4'h8) begin
                            i2c_state_q <= I2_IDLE;
                        end
                    end
                    I2_ACK_A, I2_RD_ACK: begin
                        if (rw_q && (i2c_state_q == I2_ACK_A || master_ack_q)) begin
                            sda_oe_q <= !rdata[7];
                            shift_q <= {rdata[6:0], 1'b0};
                            ptr_q <= ptr_q + 8'h01;
                            bit_q <= 4'h1;
                            i2c_state_q <= I2_RD;
                        end else if (rw_q) begin
                            sda_oe_q <= 1'b0;
                            i2c_state_q <= I2_IDLE;
                        end else begin
                            sda_oe_q <= 1'b0;
                            bit_q <= 4'h0;
                            i2c_state_q <= I2_REG;
                        end
                    end
                    I2_REG: begin
                        if (bit_q == 4'h8) begin
                            ptr_q <= shift_q;
                            sda_oe_q <= 1'b1;
                            i2c_state_q <= I2_ACK_R;
                        end
                    end
                    I2_ACK_R: begin
                        sda_oe_q <= 1'b0;
                        bit_q <= 4'h0;
                        i2c_state_q <= I2_WR;
                    end
                    I2_WR: begin
                        if (bit_q == 4'h8) begin
                            wr_q <= 1'b1;
                            waddr_q <= ptr_q;
                            wdata_q <= shift_q;
                            ptr_q <= ptr_q + 8'h01;
                            sda_oe_q <= 1'b1;
                            i2c_state_q <= I2_ACK_R;
                        end
                    end
                    I2_RD: begin
                        if (bit_q == 4'h8) begin
                            sda_oe_q <= 1'b0;
                            i2c_state_q <= I2_RD_ACK;
                        end else begin
                            sda_oe_q <= !shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Control register; the error count register is read-only
    always @(posedge clk_i) begin
        if (reset_i) begin
            control_q <= `SELFTEST_CONTROL_RESET;
        end else if (wr_q && waddr_q == `SELFTEST_CONTROL_OFFSET) begin
            control_q <= wdata_q & `CTRL_WRITE_MASK;
        end
    end
    assign session_start = (st_state_q == ST_IDLE) && test_en;
    assign frame_bad = (st_state_q == ST_CHECK) && test_en && frame_done_i && frame_error_i;
    sat_counter #(
        .WIDTH(COUNT_WIDTH)
    ) err_counter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(session_start),
        .inc_i(frame_bad),
        .count_o(err_count)
    );

    // Self-test sequence
    always @(posedge clk_i) begin
        if (reset_i) begin
            st_state_q <= ST_IDLE;
            pass_q <= 1'b0;
            checking_q <= 1'b0;
            link_normal_q <= 1'b1;
            pattern_enable_q <= 1'b0;
            remote_osc_q <= `CLK_SEL_PIXEL;
            clock_select_q <= `CLK_SEL_PIXEL;
            result_q <= 1'b0;
            err_seen_q <= 1'b0;
        end else begin
            case (st_state_q)
                ST_IDLE: begin
                    pass_q <= 1'b0;
                    checking_q <= 1'b0;
                    if (test_en) begin
                        link_normal_q <= 1'b0;
                        pattern_enable_q <= 1'b1;
                        remote_osc_q <= clk_sel;
                        clock_select_q <= clk_sel;
                        result_q <= 1'b0;
                        err_seen_q <= 1'b0;
                        st_state_q <= ST_WAIT_LOCK;
                    end
                end
                ST_WAIT_LOCK: begin
                    if (!test_en) begin
                        pattern_enable_q <= 1'b0;
                        link_normal_q <= 1'b1;
                        st_state_q <= ST_IDLE;
                    end else if (lock_i && remote_in_test_i) begin
                        pass_q <= 1'b1;
                        checking_q <= 1'b1;
                        st_state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!test_en) begin
                        // Last result stands exactly one cycle
                        pass_q <= !err_seen_q && !frame_bad;
                        result_q <= !err_seen_q;
                        checking_q <= 1'b0;
                        pattern_enable_q <= 1'b0;
                        st_state_q <= ST_RESULT;
                    end else begin
                        // One clock low per errored frame; frames never end back to back
                        pass_q <= !frame_bad;
                        if (frame_bad) begin
                            err_seen_q <= 1'b1;
                        end
                    end
                end
                ST_RESULT: begin
                    pass_q <= 1'b0;
                    link_normal_q <= 1'b1;
                    st_state_q <= ST_IDLE;
                end
                default: begin
                    st_state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
    assign pass_o = pass_q;
    assign checking_o = checking_q;
    assign link_normal_o = link_normal_q;
    assign pattern_enable_o = pattern_enable_q;
    assign remote_osc_select_o = remote_osc_q;
    assign clock_select_o = clock_select_q;
endmodule // serial_link_selftest_control

// File: dv/selftest_checker_asserts.sv
// Port assertions for the link self-test control block
`timescale 1ns/10ps
module selftest_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic selftest_enable_pin_i,
    input wire logic clock_source_select_low_i,
    input wire logic clock_source_select_high_i,
    input wire logic lock_i,
    input wire logic remote_in_test_i,
    input wire logic frame_done_i,
    input wire logic frame_error_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic pass_o,
    input wire logic checking_o,
    input wire logic link_normal_o,
    input wire logic pattern_enable_o,
    input wire logic [1:0] remote_osc_select_o,
    input wire logic [1:0] clock_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    err_pulse_a: assert property (checking_o && frame_done_i && frame_error_i |=> !pass_o)
        else $error("pass output missed an error pulse");
    result_one_a: assert property ($fell(checking_o) |=> !pass_o && link_normal_o)
        else $error("result shown longer than one cycle");
    end_stop_a: assert property ($fell(checking_o) |-> !pattern_enable_o)
        else $error("pattern still enabled after stop");
    enter_test_a: assert property ($rose(pattern_enable_o) |-> !link_normal_o && !checking_o)
        else $error("bad state on entering test");
    lock_start_a: assert property ($rose(checking_o) |-> $past(lock_i) && $past(remote_in_test_i) && pass_o)
        else $error("checking started without lock");
    pass_idle_a: assert property (pass_o && !checking_o |-> $fell(checking_o))
        else $error("pass high outside checking");
    open_drain_a: assert property (!scl_oe_o && !scl_o && !sda_o)
        else $error("line driven high or clock stretched");
    sda_hold_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line changed while clock high");
    clock_code_a: assert property (clock_select_o != 2'b11 && remote_osc_select_o != 2'b11)
        else $error("reserved clock code selected");
    cover property (checking_o && frame_done_i && frame_error_i);
    cover property ($fell(checking_o) && pass_o);
    cover property ($rose(sda_oe_o));
endmodule // selftest_checker
bind serial_link_selftest_control selftest_checker u_chk (.clk_i, .reset_i, .selftest_enable_pin_i,
    .clock_source_select_low_i, .clock_source_select_high_i, .lock_i, .remote_in_test_i, .frame_done_i,
    .frame_error_i, .scl_i, .sda_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o, .pass_o, .checking_o,
    .link_normal_o, .pattern_enable_o, .remote_osc_select_o, .clock_select_o);

// File: dv/remote_serializer_model.sv
// Behavioural far end: sends test frames once the pattern is enabled
`timescale 1ns/10ps
module remote_serializer_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pattern_enable_i,
    input wire logic [3:0] lock_delay_i,
    input wire logic [9:0] n_err_i,
    input wire logic [9:0] n_frames_i,
    output logic lock_o,
    output logic remote_in_test_o,
    output logic frame_done_o,
    output logic frame_error_o,
    output logic done_o
);
    logic [9:0] sent_q;
    logic [3:0] wait_q;
    logic gap_q;
    assign done_o = (sent_q == n_frames_i);
    always @(posedge clk_i) begin
        if (reset_i || !pattern_enable_i) begin
            {lock_o, remote_in_test_o, frame_done_o, frame_error_o, gap_q} <= 5'b0_0000;
            sent_q <= 10'h000;
            wait_q <= 4'h0;
        end else if (wait_q != lock_delay_i) begin
            wait_q <= wait_q + 4'h1; // Slow or prompt lock
        end else begin
            remote_in_test_o <= 1'b1;
            lock_o <= 1'b1;
            gap_q <= !gap_q;
            frame_done_o <= gap_q && lock_o && !done_o;
            // Error flag left high between frames on purpose
            frame_error_o <= (sent_q < n_err_i);
            if (gap_q && lock_o && !done_o) begin
                sent_q <= sent_q + 10'h001;
            end
        end
    end
endmodule // remote_serializer_model

// File: dv/test_serial_link_selftest_control.sv
// Self-checking bench for the link self-test control block
`timescale 1ns/10ps
module test_serial_link_selftest_control;
    logic clk_i = 1'b0, reset_i = 1'b1, en_pin = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, tb_scl = 1'b1, tb_sda = 1'b1;
    logic lock, in_test, f_done, f_err, m_done, scl_oe, sda_oe, pass, checking, link_normal, pat_en;
    logic [1:0] osc_sel, clk_sel;
    logic [3:0] lock_delay = 4'h0;
    logic [9:0] n_err = 10'h000, n_frames = 10'h000;
    logic [15:0] n_low;
    logic [7:0] d;
    int n_errors = 0, n_compared = 0;
    wire scl_line = tb_scl & !scl_oe;
    wire sda_line = tb_sda & !sda_oe;
    always #50 clk_i = !clk_i;
    always @(posedge clk_i) if (checking === 1'b1 && pass === 1'b0) n_low <= n_low + 16'h0001;
    serial_link_selftest_control u_dut (.clk_i(clk_i), .reset_i(reset_i), .selftest_enable_pin_i(en_pin),
        .clock_source_select_low_i(sel_lo), .clock_source_select_high_i(sel_hi), .lock_i(lock),
        .remote_in_test_i(in_test), .frame_done_i(f_done), .frame_error_i(f_err), .scl_i(scl_line),
        .sda_i(sda_line), .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .pass_o(pass),
        .checking_o(checking), .link_normal_o(link_normal), .pattern_enable_o(pat_en),
        .remote_osc_select_o(osc_sel), .clock_select_o(clk_sel));
    remote_serializer_model u_far (.clk_i(clk_i), .reset_i(reset_i), .pattern_enable_i(pat_en),
        .lock_delay_i(lock_delay), .n_err_i(n_err), .n_frames_i(n_frames), .lock_o(lock),
        .remote_in_test_o(in_test), .frame_done_o(f_done), .frame_error_o(f_err), .done_o(m_done));
    task close_out;
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #2;
        end
    endtask
    // Seven cycles a quarter keeps the bit rate under 400 kbps
    task i2c_bit(input logic b, output logic r);
        tb_sda = b;
        tick(7);
        tb_scl = 1'b1;
        // Host yields while the slave holds the clock low
        for (int k = 0; k < 64 && scl_line !== 1'b1; k++) tick(1);
        if (scl_line !== 1'b1) begin
            n_errors++;
            close_out;
        end
        tick(7);
        r = sda_line;
        tick(7);
        tb_scl = 1'b0;
        tick(7);
    endtask
    task i2c_start;
        tb_sda = 1'b1;
        tick(7);
        tb_scl = 1'b1;
        tick(7);
        tb_sda = 1'b0;
        tick(7);
        tb_scl = 1'b0;
        tick(7);
    endtask
    task i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(ack_in, ack);
    endtask
    task i2c_stop;
        tb_sda = 1'b0;
        tick(7);
        tb_scl = 1'b1;
        tick(7);
        tb_sda = 1'b1;
        tick(7);
    endtask
    task reg_access(input logic rd, input logic [7:0] off, input logic [7:0] wd, output logic [7:0] rdat);
        logic a;
        logic [7:0] x;
        i2c_start;
        i2c_byte(8'h60, 1'b1, x, a);
        check(a, 1'b0);
        i2c_byte(off, 1'b1, x, a);
        if (rd) begin
            i2c_start;
            i2c_byte(8'h61, 1'b1, x, a);
            i2c_byte(8'hff, 1'b1, rdat, a);
        end else begin
            i2c_byte(wd, 1'b1, x, a);
        end
        i2c_stop;
    endtask
    task run_session(input logic [1:0] code, input logic reg_mode, input logic [9:0] ne, input logic [9:0] nf);
        n_err = ne;
        n_frames = nf;
        lock_delay = 4'($urandom % 8);
        n_low = 16'h0000;
        if (reg_mode) reg_access(1'b0, 8'h24, {4'b0000, code, 1'b1} | 8'h08, d);
        else {sel_hi, sel_lo, en_pin} = {code, 1'b1};
        tick(1);
        check({pat_en, link_normal}, 2'b10);
        check(clk_sel, (code == 2'b11) ? 2'b00 : code);
        check(osc_sel, (code == 2'b11) ? 2'b00 : code);
        for (int k = 0; k < 3000 && m_done !== 1'b1; k++) tick(1);
        if (m_done !== 1'b1) begin
            n_errors++;
            close_out;
        end
        tick(2);
        if (reg_mode) reg_access(1'b0, 8'h24, {4'b0000, code, 1'b0} | 8'h08, d);
        else begin
            en_pin = 1'b0;
            tick(1);
            check({pass, checking}, {ne == 10'h000, 1'b0});
            tick(1);
            check({pass, link_normal}, 2'b01);
        end
        check(n_low, ne);
        reg_access(1'b1, 8'h25, 8'h00, d);
        check(d, (ne > 10'd255) ? 8'hff : ne[7:0]);
        reg_access(1'b1, 8'h24, 8'h00, d);
        check(d, {3'b000, ne == 10'h000, reg_mode, reg_mode ? code : 2'b00, 1'b0});
    endtask
    initial begin
        logic a;
        void'($urandom(4712));
        tick(6);
        reset_i = 1'b0;
        check({link_normal, pass, pat_en}, 3'b100);
        reg_access(1'b1, 8'h24, 8'h00, d);
        check(d, 8'h00);
        reg_access(1'b1, 8'h30, 8'h00, d);
        check(d, 8'h00);
        i2c_start;
        i2c_byte(8'h62, 1'b1, d, a);
        check(a, 1'b1);
        i2c_stop;
        run_session(2'b00, 1'b0, 10'd0, 10'd5);
        for (int c = 0; c < 3; c++) run_session(2'(c), 1'b0, 10'($urandom % 4), 10'(4 + $urandom % 6));
        run_session(2'b01, 1'b0, 10'd258, 10'd260);
        for (int c = 0; c < 4; c++) run_session(2'(c), 1'b1, 10'($urandom % 3), 10'd5);
        reg_access(1'b0, 8'h25, 8'haa, d);
        reg_access(1'b1, 8'h25, 8'h00, d);
        check(d, (n_err > 10'd255) ? 8'hff : n_err[7:0]);
        tick(1);
        reset_i = 1'b1;
        tick(2);
        reset_i = 1'b0;
        reg_access(1'b1, 8'h25, 8'h00, d);
        check(d, 8'h00);
        close_out;
    end
endmodule // test_serial_link_selftest_control
